// >>> dv/sgob_board_model.sv
// Board shift register chain: periodic bursts, load and input capture
`timescale 1ns/1ps
`default_nettype none
module sgob_board_model
#(
    parameter int PER = 24
)
(
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic [127:0] pins,
    output var  logic         burst_done = 1'b0,
    output var  logic         sample_valid = 1'b0,
    output var  logic [127:0] sample_in = '0
);
    int           cnt;
    logic [127:0] held;

    // Load latches pins; the next burst shifts them in
    always @(posedge ref_clk)
    begin
        burst_done <= 1'b0;
        sample_valid <= 1'b0;
        sample_in <= ~sample_in;
        cnt <= cnt + 1;
        if (!reset_n)
        begin
            cnt <= 0;
            held <= '0;
        end
        else if (cnt >= PER - 1)
        begin
            cnt <= 0;
            burst_done <= 1'b1;
            sample_valid <= 1'b1;
            sample_in <= held;
            held <= pins;
        end
    end
endmodule
`default_nettype wire

// >>> dv/sgob_core_bench.sv
// Self-checking bench for the serial GPIO core
`timescale 1ns/1ps
`default_nettype none
`include "sgob_defs.vh"
module sgob_core_bench;
    localparam int TICK = 8;
    localparam int PER = 24;
    logic         ref_clk = 1'b0;
    logic         reset_n = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic [31:0]  reg_wdata = 32'h0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [31:0]  reg_rdata;
    logic         burst_done;
    logic         sample_valid;
    logic [127:0] sample_in;
    logic [127:0] gpio;
    logic [10:0]  port_activity = 11'h0;
    logic [2:0]   pwm_in = 3'h0;
    logic [10:0]  los_gpio_pin = 11'h0;
    logic [10:0]  los_out;
    logic         irq;
    logic [127:0] pins = '0;
    int           n_mismatch = 0;
    int           checked = 0;

    sgob_core #(.TICK_CYC(TICK)) i_dut (
        .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .burst_done, .sample_valid, .sample_in,
        .serial_gpio_bit(gpio), .port_activity, .pwm_in, .los_gpio_pin,
        .los_out, .irq);
    sgob_board_model #(.PER(PER)) i_board (
        .ref_clk, .reset_n, .pins, .burst_done, .sample_valid, .sample_in);

    always #25 ref_clk = ~ref_clk;

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        cmp(reg_rdata, exp);
    endtask

    task automatic wait_burst();
        for (int i = 0; i < 100 && burst_done !== 1'b1; i++)
            cyc(1);
    endtask

    task automatic set_pins(input logic [3:0] v);
        @(posedge ref_clk);
        pins[3:0] <= v;
        cyc(3 * PER);
    endtask

    task automatic pulse();
        @(posedge ref_clk);
        port_activity <= 11'h003;
        @(posedge ref_clk);
        port_activity <= 11'h000;
    endtask

    task automatic env_check();
        int ones;
        ones = 0;
        cyc(2);
        repeat (31)
        begin
            cyc(1);
            ones += int'(gpio[2]);
            cmp(gpio[31:0], gpio[2] ? 32'h14 : 32'h28);
        end
        cmp(32'(ones >= 12), 32'h1);
    endtask

    task automatic t_regs();
        rd_chk(`SGOB_A_GENERAL, 32'h060);
        rd_chk(`SGOB_A_PORT_EN, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
        wr(`SGOB_A_RAW, 32'hffff_ffff);
        rd_chk(`SGOB_A_RAW, 32'h0);
        wr(`SGOB_A_SAMPLED, 32'h0000_00ff);
        rd_chk(`SGOB_A_SAMPLED, 32'h0);
    endtask

    task automatic t_fixed();
        wr(`SGOB_A_PORT_EN, 32'h0000_0803);
        wr(`SGOB_A_PORT_CFG, 32'h0000_2041);
        wr(`SGOB_A_PORT_CFG + 8'h01, 32'h0000_0249);
        cyc(2);
        cmp(gpio[31:0], 32'h0000_00f7);
        wr(`SGOB_A_GENERAL, 32'h020);
        cyc(2);
        cmp(gpio[31:0], 32'h0000_0033);
        wr(`SGOB_A_PORT_EN, 32'h0000_0801);
        cyc(2);
        cmp(gpio[31:0], 32'h0000_0003);
        wr(`SGOB_A_GENERAL, 32'h060);
        for (int n = 1; n < 4; n++)
        begin
            wr(`SGOB_A_PORT_CFG, (n << 16) | 32'h041);
            @(posedge ref_clk);
            pwm_in <= 3'(1 << (n - 1));
            cyc(2);
            cmp(gpio[31:0], 32'h5);
            @(posedge ref_clk);
            pwm_in <= ~3'(1 << (n - 1));
            cyc(2);
            cmp(gpio[31:0], 32'h0);
        end
    endtask

    task automatic t_blink();
        logic [31:0] m;
        logic        b;
        wr(`SGOB_A_PORT_CFG, 32'h0000_001a);
        for (int r = 0; r < 4; r++)
        begin
            m = (r < 3) ? 32'h3 : 32'h1;
            wr(`SGOB_A_GENERAL, 32'h070 | (r << 2) | r);
            cyc((TICK / 2) << r);
            cmp(gpio[31:0] & m, 32'h0);
            cyc(TICK << r);
            cmp(gpio[31:0] & m, m);
        end
        wait_burst();
        cyc(3);
        b = gpio[1];
        wait_burst();
        cyc(3);
        cmp({31'h0, gpio[1]}, {31'h0, ~b});
    endtask

    task automatic t_act();
        wr(`SGOB_A_PORT_EN, 32'h0000_0803);
        wr(`SGOB_A_GENERAL, 32'h070);
        wr(`SGOB_A_PORT_CFG, 32'h0000_0d00);
        wr(`SGOB_A_PORT_CFG + 8'h01, 32'h0000_003d);
        wr(`SGOB_A_PORT_CFG + 8'h0b, 32'h0000_0db6);
        cyc(2);
        cmp(gpio[31:0], 32'h28);
        pulse();
        env_check();
        cyc(20);
        cmp(gpio[31:0], 32'h28);
        pulse();
        cyc(20);
        pulse();
        env_check();
        cyc(20);
        cmp(gpio[31:0], 32'h28);
        cmp(gpio[63:32], 32'h0000_f000);
    endtask

    task automatic t_irq();
        wr(`SGOB_A_PORT_EN, 32'h1);
        wr(`SGOB_A_GENERAL, 32'hf60);
        wr(`SGOB_A_PORT_IRQ_EN, 32'h1);
        wr(`SGOB_A_TRIG_LO, 32'ha);
        wr(`SGOB_A_TRIG_HI, 32'hc);
        wr(`SGOB_A_STICKY, 32'hf);
        set_pins(4'hf);
        rd_chk(`SGOB_A_SAMPLED, 32'hf);
        rd_chk(`SGOB_A_STICKY, 32'hb);
        rd_chk(`SGOB_A_IDENT, 32'hb);
        cmp({31'h0, irq}, 32'h1);
        wr(`SGOB_A_STICKY, 32'hf);
        rd_chk(`SGOB_A_STICKY, 32'h1);
        set_pins(4'h0);
        rd_chk(`SGOB_A_STICKY, 32'h7);
        wr(`SGOB_A_STICKY, 32'h0);
        rd_chk(`SGOB_A_STICKY, 32'h7);
        wr(`SGOB_A_GENERAL, 32'h060);
        rd_chk(`SGOB_A_IDENT, 32'h0);
        cmp({31'h0, irq}, 32'h0);
        wr(`SGOB_A_GENERAL, 32'hf60);
        wr(`SGOB_A_PORT_IRQ_EN, 32'h0);
        cyc(1);
        cmp({31'h0, irq}, 32'h0);
        wr(`SGOB_A_PORT_IRQ_EN, 32'h1);
        wr(`SGOB_A_STICKY, 32'hf);
        cyc(1);
        cmp({31'h0, irq}, 32'h0);
        wr(`SGOB_A_POLARITY, 32'h1);
        rd_chk(`SGOB_A_RAW, 32'h1);
        cmp({21'h0, los_out}, 32'h1);
        wr(`SGOB_A_LOS_SRC, 32'h1);
        cyc(8);
        cmp({21'h0, los_out}, 32'h0);
        @(posedge ref_clk);
        los_gpio_pin <= 11'h003;
        cyc(8);
        cmp({21'h0, los_out}, 32'h1);
        @(posedge ref_clk);
        los_gpio_pin <= 11'h000;
        cyc(8);
        cmp({21'h0, los_out}, 32'h0);
    endtask

    initial
    begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_regs();
        t_fixed();
        t_blink();
        t_act();
        t_irq();
        report_and_stop();
    end

    initial
    begin
        #1_000_000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// >>> dv/sgob_core_sva.sv
// Port-level assertions for the serial GPIO core
`timescale 1ns/1ps
`default_nettype none
`include "sgob_defs.vh"
module sgob_core_sva
(
    input wire logic         ref_clk,
    input wire logic         reset_n,
    input wire logic [7:0]   reg_addr,
    input wire logic [31:0]  reg_wdata,
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    input wire logic [31:0]  reg_rdata,
    input wire logic         sample_valid,
    input wire logic [127:0] sample_in,
    input wire logic [127:0] serial_gpio_bit,
    input wire logic [10:0]  los_out,
    input wire logic         irq
);
    logic [43:0]  samp;
    logic [43:0]  pol;
    logic [43:0]  raw_lo;
    logic [31:0]  port_en;
    logic [10:0]  los_src;
    logic [10:0]  los_exp;
    logic [1:0]   width;
    logic [2:0]   cause_q;
    logic [127:0] act_mask;

    assign raw_lo = samp ^ pol;

    always_comb
    begin
        for (int i = 0; i < 128; i++)
            act_mask[i] = port_en[i / 4] && (i[1:0] <= width);
        for (int p = 0; p < 11; p++)
            los_exp[p] = raw_lo[p * 4];
    end

    // Shadow of the registers the checks depend on
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            samp <= '0;
            pol <= '0;
            port_en <= '0;
            los_src <= '0;
            width <= 2'h3;
            cause_q <= '0;
        end
        else
        begin
            cause_q <= {cause_q[1:0], sample_valid | reg_wr};
            if (sample_valid)
                samp <= sample_in[43:0];
            if (reg_wr && reg_addr == `SGOB_A_GENERAL)
                width <= reg_wdata[6:5];
            if (reg_wr && reg_addr == `SGOB_A_PORT_EN)
                port_en <= reg_wdata;
            if (reg_wr && reg_addr == `SGOB_A_LOS_SRC)
                los_src <= reg_wdata[10:0];
            if (reg_wr && reg_addr == `SGOB_A_POLARITY)
                pol[31:0] <= reg_wdata;
            if (reg_wr && reg_addr == `SGOB_A_POLARITY + 8'h01)
                pol[43:32] <= reg_wdata[11:0];
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    unmapped_zero_a: assert property (
        $past(reg_rd && reg_addr >= 8'h40) |-> reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    sampled_read_a: assert property (
        $past(reg_rd && reg_addr == `SGOB_A_SAMPLED)
        |-> reg_rdata == $past(samp[31:0]))
        else $error("sampled input word wrong");
    raw_read_a: assert property (
        $past(reg_rd && reg_addr == `SGOB_A_RAW)
        |-> reg_rdata == $past(raw_lo[31:0]))
        else $error("raw status word wrong");
    ident_irq_a: assert property (
        $past(reg_rd && reg_addr[7:2] == 6'h07) && reg_rdata != 32'h0
        |-> $past(irq))
        else $error("identified bits set while irq low");
    irq_hold_a: assert property (
        $fell(irq) |-> $past(reg_wr))
        else $error("irq dropped without a register write");
    irq_cause_a: assert property (
        $rose(irq) |-> cause_q != 3'h0)
        else $error("irq rose without sample or write");
    los_follow_a: assert property (
        1'b1 |=> ((los_out ^ $past(los_exp)) & ~$past(los_src)) == 11'h0)
        else $error("loss of signal differs from raw bit");
    masked_zero_a: assert property (
        1'b1 |=> (serial_gpio_bit & ~$past(act_mask)) == 128'h0)
        else $error("inactive output bit not zero");

    irq_seen_c: cover property ($rose(irq));
    los_seen_c: cover property ($rose(los_out[0]));
    ident_read_c: cover property (
        $past(reg_rd && reg_addr == `SGOB_A_IDENT) && reg_rdata != 32'h0);
endmodule

bind sgob_core sgob_core_sva i_sva (
    .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sample_valid, .sample_in, .serial_gpio_bit,
    .los_out, .irq);
`default_nettype wire

// >>> include/sgob_defs.vh
// Constants for the serial GPIO output and interrupt block
`ifndef SGOB_DEFS_VH
`define SGOB_DEFS_VH

// Clock and timing
`define SGOB_CLK_HZ         20000000
`define SGOB_TICK_US        25000
`define SGOB_TICK_CYC       ((`SGOB_CLK_HZ / 1000000) * `SGOB_TICK_US)
`define SGOB_STRETCH_MS     100
`define SGOB_STRETCH_TICKS  (((`SGOB_STRETCH_MS * 1000) + `SGOB_TICK_US - 1) / `SGOB_TICK_US + 1)

// Register indices
`define SGOB_A_GENERAL      8'h00
`define SGOB_A_PORT_EN      8'h01
`define SGOB_A_PORT_IRQ_EN  8'h02
`define SGOB_A_LOS_SRC      8'h03
`define SGOB_A_SAMPLED      8'h04
`define SGOB_A_POLARITY     8'h08
`define SGOB_A_RAW          8'h0c
`define SGOB_A_TRIG_LO      8'h10
`define SGOB_A_TRIG_HI      8'h14
`define SGOB_A_STICKY       8'h18
`define SGOB_A_IDENT        8'h1c
`define SGOB_A_PORT_CFG     8'h20

// General config fields
`define SGOB_G_RATE0_LSB    0
`define SGOB_G_RATE1_LSB    2
`define SGOB_G_BLINK_CLR    4
`define SGOB_G_WIDTH_LSB    5
`define SGOB_G_POSEN_LSB    8
`define SGOB_GENERAL_RST    12'h060

// Per-port output config fields
`define SGOB_P_SRC_LSB      0
`define SGOB_P_POL_LSB      12
`define SGOB_P_PWM_LSB      16
`define SGOB_PCFG_RST       18'h00000

// Bit source codes
`define SGOB_SRC_FIX0       3'h0
`define SGOB_SRC_FIX1       3'h1
`define SGOB_SRC_BLINK0     3'h2
`define SGOB_SRC_BLINK1     3'h3
`define SGOB_SRC_ACT0       3'h4
`define SGOB_SRC_ACT1       3'h5
`define SGOB_SRC_ACT0_N     3'h6
`define SGOB_SRC_ACT1_N     3'h7

// Trigger mode codes {high, low}
`define SGOB_TRG_LEVEL      2'h0
`define SGOB_TRG_ANY        2'h1
`define SGOB_TRG_FALL       2'h2
`define SGOB_TRG_RISE       2'h3

`define SGOB_RATE1_BURST    2'h3
`define SGOB_NUM_MODULES    11

`endif

// >>> logic/sgob_core.v
// Serial GPIO per-bit output modes, interrupts and loss-of-signal forwarding
`include "sgob_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module sgob_core
#(
    parameter integer TICK_CYC = `SGOB_TICK_CYC
)
(
    input  wire         ref_clk,
    input  wire         reset_n,
    input  wire [7:0]   reg_addr,
    input  wire [31:0]  reg_wdata,
    input  wire         reg_wr,
    input  wire         reg_rd,
    output reg  [31:0]  reg_rdata,
    input  wire         burst_done,
    input  wire         sample_valid,
    input  wire [127:0] sample_in,
    output reg  [127:0] serial_gpio_bit,
    input  wire [10:0]  port_activity,
    input  wire [2:0]   pwm_in,
    input  wire [10:0]  los_gpio_pin,
    output reg  [10:0]  los_out,
    output wire         irq
);

    localparam integer STRETCH = `SGOB_STRETCH_TICKS;

    // Configuration storage
    reg  [11:0] serial_general_config;
    reg  [31:0] port_shift_enable;
    reg  [31:0] port_irq_enable;
    reg  [10:0] los_source;
    reg  [127:0] sampled_inputs;
    reg  [127:0] input_polarity;
    reg  [127:0] trigger_mode_low;
    reg  [127:0] trigger_mode_high;
    reg  [127:0] sticky_irq_flags;
    reg  [127:0] prev_raw;
    reg  [17:0] per_port_output_config [0:31];

    // Timing state
    reg  [19:0] prescale;
    reg         tick;
    reg  [3:0]  blink_div;
    reg         burst_toggle;
    reg  [2:0]  stretch_cnt [0:10];

    // Loss-of-signal pin synchroniser
    reg  [10:0] los_s1;
    reg  [10:0] los_s2;
    reg  [10:0] los_s3;
    reg  [10:0] los_gpio;

    wire [1:0]  blink_rate_0 = serial_general_config[`SGOB_G_RATE0_LSB +: 2];
    wire [1:0]  blink_rate_1 = serial_general_config[`SGOB_G_RATE1_LSB +: 2];
    wire [1:0]  bits_per_port = serial_general_config[`SGOB_G_WIDTH_LSB +: 2];
    wire [3:0]  position_irq_enable =
        serial_general_config[`SGOB_G_POSEN_LSB +: 4];
    wire        blink_counter_clear = reg_wr &&
        reg_addr == `SGOB_A_GENERAL && reg_wdata[`SGOB_G_BLINK_CLR];

    wire [127:0] raw_irq_status;
    reg  [127:0] bit_active;
    reg  [127:0] irq_mask;
    reg  [127:0] trig_set;
    reg  [127:0] w1c;
    reg  [10:0]  envelope;
    wire [127:0] identified_irq;
    wire         blink0;
    wire         blink1;

    // Bit index active when port enabled and position within width
    function bit_used;
        input [31:0] en;
        input [1:0]  width;
        input [6:0]  idx;
        begin
            bit_used = en[idx[6:2]] && (idx[1:0] <= width);
        end
    endfunction

    // Source selection for one bit
    function src_val;
        input [2:0] src;
        input       b0;
        input       b1;
        input       env;
        begin
            case (src)
                `SGOB_SRC_FIX0:   src_val = 1'b0;
                `SGOB_SRC_FIX1:   src_val = 1'b1;
                `SGOB_SRC_BLINK0: src_val = b0;
                `SGOB_SRC_BLINK1: src_val = b1;
                `SGOB_SRC_ACT0:   src_val = env & b0;
                `SGOB_SRC_ACT1:   src_val = env & b1;
                `SGOB_SRC_ACT0_N: src_val = ~(env & b0);
                `SGOB_SRC_ACT1_N: src_val = ~(env & b1);
                default:          src_val = 1'b0;
            endcase
        end
    endfunction

    // Timebase prescaler and blink divider
    // prescaled tick
    always @(posedge ref_clk)
    begin
        if (!reset_n || blink_counter_clear)
        begin
            prescale <= 20'h00000;
            tick     <= 1'b0;
        end
        else if (prescale == TICK_CYC[19:0] - 20'h00001)
        begin
            prescale <= 20'h00000;
            tick     <= 1'b1;
        end
        else
        begin
            prescale <= prescale + 20'h00001;
            tick     <= 1'b0;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!reset_n || blink_counter_clear)
        begin
            blink_div    <= 4'h0;
            burst_toggle <= 1'b0;
        end
        else
        begin
            if (tick)
                blink_div <= blink_div + 4'h1;
            if (burst_done)
                burst_toggle <= ~burst_toggle;
        end
    end

    assign blink0 = blink_div[blink_rate_0];
    assign blink1 = (blink_rate_1 == `SGOB_RATE1_BURST) ? burst_toggle :
                    blink_div[blink_rate_1];

    // Activity envelope per port module
    always @(posedge ref_clk)
    begin : stretch_upd
        integer i;
        for (i = 0; i < `SGOB_NUM_MODULES; i = i + 1)
        begin
            if (!reset_n)
                stretch_cnt[i] <= 3'h0;
            else if (port_activity[i])
                stretch_cnt[i] <= STRETCH[2:0];
            else if (tick && stretch_cnt[i] != 3'h0)
                stretch_cnt[i] <= stretch_cnt[i] - 3'h1;
        end
    end

    always @*
    begin : env_dec
        integer i;
        i = 0;
        for (i = 0; i < `SGOB_NUM_MODULES; i = i + 1)
            envelope[i] = (stretch_cnt[i] != 3'h0);
    end

    // Per-bit output generation
    always @(posedge ref_clk)
    begin : out_gen
        reg [17:0] c;
        reg        env;
        reg        v;
        reg [1:0]  pw;
        integer    i;
        c   = 18'h00000;
        env = 1'b0;
        v   = 1'b0;
        pw  = 2'h0;
        for (i = 0; i < 128; i = i + 1)
        begin
            c   = per_port_output_config[i / 4];
            env = (i / 4 < `SGOB_NUM_MODULES) ? envelope[i / 4] : 1'b0;
            v   = src_val(c[`SGOB_P_SRC_LSB + 3 * (i % 4) +: 3],
                          blink0, blink1, env);
            pw  = c[`SGOB_P_PWM_LSB +: 2];
            if (pw != 2'h0)
                v = v & pwm_in[pw - 2'h1];
            v = v ^ c[`SGOB_P_POL_LSB + (i % 4)];
            if (!reset_n)
                serial_gpio_bit[i] <= 1'b0;
            else
                serial_gpio_bit[i] <= v & bit_active[i];
        end
    end

    // Enables and trigger decode
    always @*
    begin : en_dec
        integer i;
        i = 0;
        for (i = 0; i < 128; i = i + 1)
        begin
            bit_active[i] = bit_used(port_shift_enable, bits_per_port,
                                     i[6:0]);
            irq_mask[i] = port_irq_enable[i / 4] &
                          position_irq_enable[i % 4] & bit_active[i];
            case ({trigger_mode_high[i], trigger_mode_low[i]})
                `SGOB_TRG_LEVEL: trig_set[i] = raw_irq_status[i];
                `SGOB_TRG_ANY:   trig_set[i] = raw_irq_status[i] ^ prev_raw[i];
                `SGOB_TRG_FALL:  trig_set[i] = prev_raw[i] & ~raw_irq_status[i];
                `SGOB_TRG_RISE:  trig_set[i] = raw_irq_status[i] & ~prev_raw[i];
                default:         trig_set[i] = 1'b0;
            endcase
            trig_set[i] = trig_set[i] & bit_active[i];
        end
    end

    assign raw_irq_status = sampled_inputs ^ input_polarity;
    assign identified_irq = sticky_irq_flags & irq_mask;
    assign irq = |identified_irq;

    // Write-one-clear mask for sticky flags
    always @*
    begin
        w1c = 128'h0;
        if (reg_wr && reg_addr[7:2] == `SGOB_A_STICKY >> 2)
            w1c[reg_addr[1:0] * 32 +: 32] = reg_wdata;
    end

    // Sticky flags and input capture
    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            sampled_inputs   <= 128'h0;
            prev_raw         <= 128'h0;
            sticky_irq_flags <= 128'h0;
        end
        else
        begin
            if (sample_valid)
                sampled_inputs <= sample_in;
            prev_raw <= raw_irq_status;
            sticky_irq_flags <= (sticky_irq_flags & ~w1c) | trig_set;
        end
    end

    // Loss-of-signal GPIO path, changes when stages two and three agree
    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            los_s1   <= 11'h000;
            los_s2   <= 11'h000;
            los_s3   <= 11'h000;
            los_gpio <= 11'h000;
        end
        else
        begin
            los_s1 <= los_gpio_pin;
            los_s2 <= los_s1;
            los_s3 <= los_s2;
            // Hold while stages disagree, follow once they agree
            los_gpio <= (los_gpio & (los_s2 ^ los_s3)) |
                        (los_s2 & ~(los_s2 ^ los_s3));
        end
    end

    always @(posedge ref_clk)
    begin : los_upd
        integer i;
        for (i = 0; i < `SGOB_NUM_MODULES; i = i + 1)
        begin
            if (!reset_n)
                los_out[i] <= 1'b0;
            else if (los_source[i])
                los_out[i] <= los_gpio[i];
            else
                los_out[i] <= raw_irq_status[i * 4];
        end
    end

    // Register writes
    always @(posedge ref_clk)
    begin : cfg_write
        integer i;
        if (!reset_n)
        begin
            serial_general_config <= `SGOB_GENERAL_RST;
            port_shift_enable     <= 32'h00000000;
            port_irq_enable       <= 32'h00000000;
            los_source            <= 11'h000;
            input_polarity        <= 128'h0;
            trigger_mode_low      <= 128'h0;
            trigger_mode_high     <= 128'h0;
            for (i = 0; i < 32; i = i + 1)
                per_port_output_config[i] <= `SGOB_PCFG_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr[7:2])
                `SGOB_A_GENERAL >> 2:
                begin
                    if (reg_addr == `SGOB_A_GENERAL)
                        serial_general_config <= reg_wdata[11:0] &
                            ~(12'h001 << `SGOB_G_BLINK_CLR);
                    else if (reg_addr == `SGOB_A_PORT_EN)
                        port_shift_enable <= reg_wdata;
                    else if (reg_addr == `SGOB_A_PORT_IRQ_EN)
                        port_irq_enable <= reg_wdata;
                    else
                        los_source <= reg_wdata[10:0];
                end
                `SGOB_A_POLARITY >> 2:
                    input_polarity[reg_addr[1:0] * 32 +: 32] <= reg_wdata;
                `SGOB_A_TRIG_LO >> 2:
                    trigger_mode_low[reg_addr[1:0] * 32 +: 32] <= reg_wdata;
                `SGOB_A_TRIG_HI >> 2:
                    trigger_mode_high[reg_addr[1:0] * 32 +: 32] <= reg_wdata;
                default:
                    if (reg_addr[7:5] == 3'h1)
                        per_port_output_config[reg_addr[4:0]] <=
                            reg_wdata[17:0];
            endcase
        end
    end

    // Register reads, data one cycle after strobe
    always @(posedge ref_clk)
    begin
        if (!reset_n || !reg_rd)
            reg_rdata <= 32'h00000000;
        else
        begin
            case (reg_addr[7:2])
                `SGOB_A_GENERAL >> 2:
                    case (reg_addr[1:0])
                        2'h0:    reg_rdata <= {20'h00000,
                                               serial_general_config};
                        2'h1:    reg_rdata <= port_shift_enable;
                        2'h2:    reg_rdata <= port_irq_enable;
                        default: reg_rdata <= {21'h000000, los_source};
                    endcase
                `SGOB_A_SAMPLED >> 2:
                    reg_rdata <= sampled_inputs[reg_addr[1:0] * 32 +: 32];
                `SGOB_A_POLARITY >> 2:
                    reg_rdata <= input_polarity[reg_addr[1:0] * 32 +: 32];
                `SGOB_A_RAW >> 2:
                    reg_rdata <= raw_irq_status[reg_addr[1:0] * 32 +: 32];
                `SGOB_A_TRIG_LO >> 2:
                    reg_rdata <= trigger_mode_low[reg_addr[1:0] * 32 +: 32];
                `SGOB_A_TRIG_HI >> 2:
                    reg_rdata <= trigger_mode_high[reg_addr[1:0] * 32 +: 32];
                `SGOB_A_STICKY >> 2:
                    reg_rdata <= sticky_irq_flags[reg_addr[1:0] * 32 +: 32];
                `SGOB_A_IDENT >> 2:
                    reg_rdata <= identified_irq[reg_addr[1:0] * 32 +: 32];
                default:
                    if (reg_addr[7:5] == 3'h1)
                        reg_rdata <= {14'h0000,
                            per_port_output_config[reg_addr[4:0]]};
                    else
                        reg_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule

`default_nettype wire
